// file: logic/timer_capture_regs.vh
// register map, field positions, reset values and mode codes of the capture timer block
// Operation
// - two-bit edge field: 00 off, 01 rising, 10 falling, 11 both edges
// - capture edge register: ch3 bits 7:6, ch2 5:4, ch1 3:2, ch0 1:0
// - capture edges act only in free-running and pulse width modes
// - input edge bits 3:2 select event count input edge
// - input edge bits 1:0 select trigger input edge; bits 7:4 read zero
// - event edge acts only with event enable set or event count mode
// - trigger edge acts only in trigger pulse or one-shot modes
// - option bits 7:4 pick capture or compare, free-running mode only
// - wrap flag bit 0 sets on counter wrap in free-running or pulse width
// - wrap interrupt fires with flag set, only in those two modes
// - reading flag or option register never clears the flag
// - flag clears on software write of zero or while counter stopped
// - software write of one neither sets flag nor affects timer
// - ch0 is capture/compare in free-running, capture in pulse width, else compare
// - ch0 register 16 bits, resets zero, readable and writable while running
// - 8-bit registers reset zero and take byte or single-bit access
// - ch0 match raises interrupt, toggles output if enabled, clears counter in cycles
// - ch0 capture edge stores counter; pulse width mode also clears counter
// - mode field: free-running 101, pulse width measurement 110
`ifndef TIMER_CAPTURE_REGS_VH
`define TIMER_CAPTURE_REGS_VH
`define ADDR_CAPTURE_EDGE  32'h0ffff543
`define ADDR_EVENT_TRIG    32'hfffff544
`define ADDR_CAPTURE_MODE  32'hfffff545
`define ADDR_CH0_CC        32'hfffff546
`define RST_BYTE           8'h00
`define RST_CC             16'h0000
`define CNT_MAX            16'hffff
`define CNT_ZERO           16'h0000
`define EVT_EDGE_LSB       2
`define TRG_EDGE_LSB       0
`define CCS_LSB            4
`define WRAP_BIT           0
`define EDGE_OFF           2'h0
`define EDGE_RISE          2'h1
`define EDGE_FALL          2'h2
`define EDGE_BOTH          2'h3
`define MODE_INTERVAL      3'h0
`define MODE_EVENT         3'h1
`define MODE_EXT_TRIG      3'h2
`define MODE_ONE_SHOT      3'h3
`define MODE_PWM           3'h4
`define MODE_FREE_RUN      3'h5
`define MODE_PULSE_WIDTH   3'h6
`define MODE_TRIANGLE      3'h7
`endif

// file: logic/pin_edge_sync.v
// two-stage synchroniser with rising and falling edge pulses for one pin
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
   input  wire core_clk,
   input  wire sys_rst,
   input  wire pin_in,
   output wire rise_pulse,
   output wire fall_pulse
);
   reg meta_q;
   reg sync_q;
   reg last_q;

   // meta_q feeds only sync_q; edges compare the settled stages
   always @(posedge core_clk) begin
      if (sys_rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // each transition yields its own one-cycle pulse
   assign rise_pulse = sync_q & ~last_q;
   assign fall_pulse = ~sync_q & last_q;
endmodule // pin_edge_sync
`default_nettype wire

// file: logic/timer_capture_edge_overflow.v
// edge selection, capture/compare choice, wrap flag and channel 0 register of the timer
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "timer_capture_regs.vh"
module timer_capture_edge_overflow (
   input  wire        core_clk,
   input  wire        sys_rst,
   input  wire [31:0] reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   input  wire        trigger_input_ch0,
   input  wire        trigger_input_ch1,
   input  wire        trigger_input_ch2,
   input  wire        trigger_input_ch3,
   input  wire        counter_enable_bit,
   input  wire [2:0]  timer_mode_field,
   input  wire        external_event_enable,
   input  wire [15:0] counter_value,
   input  wire        ch0_output_enable,
   output reg  [3:0]  capture_pulse,
   output reg  [3:0]  capture_role,
   output reg         event_count_pulse,
   output reg         trigger_pulse,
   output reg         counter_clear,
   output reg         wrap_interrupt,
   output reg         ch0_match_interrupt,
   output reg         timer_output_ch0
);

   // decode of a two-bit edge field against the edge pulses
   function edge_hit;
      input [1:0] sel;
      input       rise;
      input       fall;
      begin
         case (sel)
            `EDGE_RISE: edge_hit = rise;
            `EDGE_FALL: edge_hit = fall;
            `EDGE_BOTH: edge_hit = rise | fall;
            default:    edge_hit = 1'b0;
         endcase
      end
   endfunction

   // registers
   reg  [7:0]  capture_edge_select_q;
   reg  [3:0]  event_trigger_edge_select_q;
   reg  [3:0]  channel_capture_select_q;
   reg         counter_wrap_flag_q;
   reg  [15:0] channel0_capture_compare_q;
   reg  [15:0] ch0_compare_buffer_q;
   reg  [15:0] counter_last_q;
   reg         match_level_q;

   // pin edges
   wire [3:0]  pin_vec;
   wire [3:0]  rise_vec;
   wire [3:0]  fall_vec;

   // decodes
   wire        sel_edge;
   wire        sel_trig;
   wire        sel_mode;
   wire        sel_cc;
   wire        wr_edge;
   wire        wr_trig;
   wire        wr_mode;
   wire        wr_cc;
   wire        mode_free;
   wire        mode_width;
   wire        mode_capture_ok;
   wire        mode_cycle;
   wire        mode_batch;
   wire        event_ok;
   wire        trigger_ok;
   wire        counter_wrap;
   wire        ch0_is_capture;
   wire        ch0_capture_now;
   wire        match_level;
   wire        match_rise;
   wire [3:0]  capture_now;
   wire [3:0]  role_now;
   wire        event_now;
   wire        trigger_now;
   reg  [15:0] read_mux;

   assign pin_vec = {trigger_input_ch3, trigger_input_ch2,
                     trigger_input_ch1, trigger_input_ch0};

   // one synchroniser per pin; ch0 pin also serves event and trigger
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         pin_edge_sync u_sync (
            .core_clk   (core_clk),
            .sys_rst    (sys_rst),
            .pin_in     (pin_vec[gi]),
            .rise_pulse (rise_vec[gi]),
            .fall_pulse (fall_vec[gi])
         );
      end
   endgenerate

   // address decode on the printed offsets
   assign sel_edge = (reg_addr == `ADDR_CAPTURE_EDGE);
   assign sel_trig = (reg_addr == `ADDR_EVENT_TRIG);
   assign sel_mode = (reg_addr == `ADDR_CAPTURE_MODE);
   assign sel_cc   = (reg_addr == `ADDR_CH0_CC);
   assign wr_edge  = reg_wr & sel_edge;
   assign wr_trig  = reg_wr & sel_trig;
   assign wr_mode  = reg_wr & sel_mode;
   assign wr_cc    = reg_wr & sel_cc;

   // mode classes
   assign mode_free  = (timer_mode_field == `MODE_FREE_RUN);
   assign mode_width = (timer_mode_field == `MODE_PULSE_WIDTH);
   assign mode_capture_ok = mode_free | mode_width;
   assign mode_cycle = ~mode_capture_ok;
   // batch-write modes load the buffer only at the cycle boundary while the counter runs
   assign mode_batch = (timer_mode_field == `MODE_EXT_TRIG) |
                       (timer_mode_field == `MODE_PWM) |
                       (timer_mode_field == `MODE_TRIANGLE);
   assign event_ok = external_event_enable |
                     (timer_mode_field == `MODE_EVENT);
   assign trigger_ok = (timer_mode_field == `MODE_EXT_TRIG) |
                       (timer_mode_field == `MODE_ONE_SHOT);

   // per-channel role and qualified capture edges
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
         // capture in width mode, chosen in free-run, compare elsewhere
         assign role_now[gi] = mode_width |
                               (mode_free & channel_capture_select_q[gi]);
         assign capture_now[gi] = counter_enable_bit & mode_capture_ok &
                                  role_now[gi] &
                                  edge_hit(capture_edge_select_q[2*gi+1:2*gi],
                                           rise_vec[gi], fall_vec[gi]);
      end
   endgenerate

   assign ch0_is_capture  = role_now[0];
   assign ch0_capture_now = capture_now[0];

   // event and trigger share the ch0 pin edges
   assign event_now = counter_enable_bit & event_ok &
                      edge_hit(event_trigger_edge_select_q[`EVT_EDGE_LSB+1:`EVT_EDGE_LSB],
                               rise_vec[0], fall_vec[0]);
   assign trigger_now = counter_enable_bit & trigger_ok &
                        edge_hit(event_trigger_edge_select_q[`TRG_EDGE_LSB+1:`TRG_EDGE_LSB],
                                 rise_vec[0], fall_vec[0]);

   // wrap seen as max followed by zero on the shared counter
   assign counter_wrap = counter_enable_bit & mode_capture_ok &
                         (counter_last_q == `CNT_MAX) &
                         (counter_value == `CNT_ZERO);

   // compare is level on equality; the pulse marks its start so that a
   // prescaled counter resting on the value raises only one event
   assign match_level = counter_enable_bit & ~ch0_is_capture &
                        (counter_value == ch0_compare_buffer_q);
   assign match_rise  = match_level & ~match_level_q;

   // 8-bit control registers
   always @(posedge core_clk) begin
      if (sys_rst) begin
         capture_edge_select_q       <= `RST_BYTE;
         event_trigger_edge_select_q <= 4'h0;
         channel_capture_select_q    <= 4'h0;
      end else begin
         if (wr_edge) begin
            capture_edge_select_q <= reg_wdata[7:0];
         end
         if (wr_trig) begin
            event_trigger_edge_select_q <= reg_wdata[3:0];
         end
         if (wr_mode) begin
            channel_capture_select_q <= reg_wdata[`CCS_LSB+3:`CCS_LSB];
         end
      end
   end

   // wrap flag: a wrap in the clearing cycle wins over a written zero
   always @(posedge core_clk) begin
      if (sys_rst) begin
         counter_wrap_flag_q <= 1'b0;
      end else if (!counter_enable_bit) begin
         counter_wrap_flag_q <= 1'b0;
      end else if (counter_wrap) begin
         counter_wrap_flag_q <= 1'b1;
      end else if (wr_mode && !reg_wdata[`WRAP_BIT]) begin
         counter_wrap_flag_q <= 1'b0;
      end
   end

   // channel 0 register; a capture beats a write in the same cycle
   always @(posedge core_clk) begin
      if (sys_rst) begin
         channel0_capture_compare_q <= `RST_CC;
      end else if (ch0_capture_now) begin
         channel0_capture_compare_q <= counter_value;
      end else if (wr_cc) begin
         channel0_capture_compare_q <= reg_wdata;
      end
   end

   // compare buffer: anytime load, or at counter clear in batch modes
   always @(posedge core_clk) begin
      if (sys_rst) begin
         ch0_compare_buffer_q <= `RST_CC;
      end else if (!counter_enable_bit || !mode_batch) begin
         ch0_compare_buffer_q <= channel0_capture_compare_q;
      end else if (match_rise) begin
         ch0_compare_buffer_q <= channel0_capture_compare_q;
      end
   end

   // history for wrap and match edge detection
   always @(posedge core_clk) begin
      if (sys_rst) begin
         counter_last_q <= `CNT_ZERO;
         match_level_q  <= 1'b0;
      end else begin
         counter_last_q <= counter_value;
         match_level_q  <= match_level;
      end
   end

   // registered event outputs to the rest of the timer
   always @(posedge core_clk) begin
      if (sys_rst) begin
         capture_pulse       <= 4'h0;
         capture_role        <= 4'h0;
         event_count_pulse   <= 1'b0;
         trigger_pulse       <= 1'b0;
         counter_clear       <= 1'b0;
         wrap_interrupt      <= 1'b0;
         ch0_match_interrupt <= 1'b0;
      end else begin
         capture_pulse       <= capture_now;
         capture_role        <= role_now;
         event_count_pulse   <= event_now;
         trigger_pulse       <= trigger_now;
         counter_clear       <= (ch0_capture_now & mode_width) |
                                (match_rise & mode_cycle);
         wrap_interrupt      <= counter_wrap;
         ch0_match_interrupt <= match_rise;
      end
   end

   // output toggles on each match while ch0_output_enable is set; held low while the counter is stopped
   always @(posedge core_clk) begin
      if (sys_rst) begin
         timer_output_ch0 <= 1'b0;
      end else if (!counter_enable_bit) begin
         timer_output_ch0 <= 1'b0;
      end else if (match_rise && ch0_output_enable) begin
         timer_output_ch0 <= ~timer_output_ch0;
      end
   end

   // read mux; reads have no side effect on any flag
   always @* begin
      read_mux = 16'h0000;
      if (sel_edge) begin
         read_mux = {8'h00, capture_edge_select_q};
      end else if (sel_trig) begin
         read_mux = {12'h000, event_trigger_edge_select_q};
      end else if (sel_mode) begin
         read_mux = {8'h00, channel_capture_select_q, 3'h0,
                     counter_wrap_flag_q};
      end else if (sel_cc) begin
         read_mux = channel0_capture_compare_q;
      end
   end

   // read data stand only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= read_mux;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule // timer_capture_edge_overflow
`default_nettype wire

// file: bench/pin_driver.sv
// model of the four capture pins, each flipped on request at a clock edge
`timescale 1ns/100ps
`default_nettype none
module pin_driver (
   input  wire logic       core_clk,
   input  wire logic [3:0] flip,
   output var  logic [3:0] pins
);
   // pins move only at edges, so every level holds at least one full cycle
   initial pins = 4'h0;
   always @(posedge core_clk) begin
      pins <= pins ^ flip;
   end
endmodule // pin_driver
`default_nettype wire

// file: bench/timer_capture_edge_overflow_props.sv
// port-level timing checks of the capture and wrap block
`timescale 1ns/100ps
`default_nettype none
module timer_capture_props (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        counter_enable_bit,
   input wire logic [2:0]  timer_mode_field,
   input wire logic        external_event_enable,
   input wire logic [15:0] counter_value,
   input wire logic [3:0]  capture_pulse,
   input wire logic [3:0]  capture_role,
   input wire logic        event_count_pulse,
   input wire logic        trigger_pulse,
   input wire logic        counter_clear,
   input wire logic        wrap_interrupt,
   input wire logic        timer_output_ch0
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // counter passes from its maximum to zero while running in a capture mode
   sequence s_wrap;
      counter_value == 16'hffff ##1 counter_value == 16'h0000 && counter_enable_bit &&
         timer_mode_field inside {3'h5, 3'h6};
   endsequence
   AST_WRAP_PULSE: assert property (s_wrap |=> wrap_interrupt ##1 !wrap_interrupt)
      else $error("wrap pulse missing or too long");
   AST_WRAP_MODE: assert property (wrap_interrupt |-> $past(timer_mode_field) inside {3'h5, 3'h6})
      else $error("wrap pulse in a non-capture mode");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   AST_ROLE_PW: assert property ($past(timer_mode_field) == 3'h6 |-> capture_role == 4'hf)
      else $error("pulse width mode not in capture role");
   AST_CAP_QUAL: assert property (capture_pulse != 4'h0 |-> $past(counter_enable_bit) && $past(timer_mode_field) inside {3'h5, 3'h6})
      else $error("capture outside capture modes");
   AST_EVT_QUAL: assert property (event_count_pulse |-> $past(external_event_enable) || $past(timer_mode_field) == 3'h1)
      else $error("event edge while event input off");
   AST_TRG_QUAL: assert property (trigger_pulse |-> $past(timer_mode_field) inside {3'h2, 3'h3})
      else $error("trigger edge outside trigger modes");
   AST_PW_CLEAR: assert property (capture_pulse[0] && $past(timer_mode_field) == 3'h6 |-> counter_clear)
      else $error("pulse width capture without counter clear");
   AST_OUT_IDLE: assert property (!$past(counter_enable_bit) |-> !timer_output_ch0)
      else $error("channel 0 output high while stopped");
endmodule // timer_capture_props
bind timer_capture_edge_overflow timer_capture_props chk_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .counter_enable_bit(counter_enable_bit), .timer_mode_field(timer_mode_field),
   .external_event_enable(external_event_enable), .counter_value(counter_value),
   .capture_pulse(capture_pulse), .capture_role(capture_role),
   .event_count_pulse(event_count_pulse), .trigger_pulse(trigger_pulse),
   .counter_clear(counter_clear), .wrap_interrupt(wrap_interrupt),
   .timer_output_ch0(timer_output_ch0));
`default_nettype wire

// file: bench/timer_capture_edge_overflow_test.sv
// self-checking bench of edge selection, wrap flag and channel 0 register
`timescale 1ns/100ps
`default_nettype none
`include "timer_capture_regs.vh"
module timer_capture_edge_overflow_test;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [31:0] reg_addr = 32'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   wire  [15:0] reg_rdata;
   logic [3:0]  flip = 4'h0;
   wire  [3:0]  pins;
   logic        en = 1'b0;
   logic [2:0]  mode = 3'h0;
   logic        eee = 1'b0;
   logic [15:0] cnt = 16'h0;
   wire  [3:0]  cap;
   wire         evt, trg;
   wire         mi, clr, wrp, tout;
   logic        oe = 1'b1;
   int          n_mi = 0, n_clr = 0, n_wrp = 0;
   logic [31:0] rng = 32'h2a;
   logic [1:0]  c;
   logic [2:0]  m;
   logic [2:0]  mt [6] = '{3'h5, 3'h6, 3'h1, 3'h2, 3'h3, 3'h0};
   int          num_errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          sel = 0, f, n_sel = 0, n_all = 0, n_evt = 0, n_trg = 0, b1, b2, b3, b4;
   always #2 core_clk = ~core_clk;
   pin_driver pins_i (.core_clk(core_clk), .flip(flip), .pins(pins));
   timer_capture_edge_overflow uut (
      .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_input_ch0(pins[0]),
      .trigger_input_ch1(pins[1]), .trigger_input_ch2(pins[2]), .trigger_input_ch3(pins[3]),
      .counter_enable_bit(en), .timer_mode_field(mode), .external_event_enable(eee),
      .counter_value(cnt), .ch0_output_enable(oe), .capture_pulse(cap), .capture_role(),
      .event_count_pulse(evt), .trigger_pulse(trg), .counter_clear(clr), .wrap_interrupt(wrp),
      .ch0_match_interrupt(mi), .timer_output_ch0(tout));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // valid edges produced by one rise and one fall of a pin
   function automatic int edges(input logic [1:0] k);
      return (k == 2'h0) ? 0 : (k == 2'h3) ? 2 : 1;
   endfunction
   task conclude;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [31:0] a, input logic [15:0] w);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read data is taken in the one cycle after the strobe
   task rchk(input logic [31:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      chk(reg_rdata, exp);
   endtask
   task pulse_pins;
      repeat (2) begin
         @(posedge core_clk);
         flip <= 4'hf;
         @(posedge core_clk);
         flip <= 4'h0;
         repeat (6) @(posedge core_clk);
      end
   endtask
   task wrap_once;
      @(posedge core_clk);
      cnt <= 16'hffff;
      @(posedge core_clk);
      cnt <= 16'h0000;
      repeat (2) @(posedge core_clk);
   endtask
   // pulse tallies; the cycle ceiling cuts a hang short
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      n_sel <= n_sel + cap[sel];
      n_all <= n_all + $countones(cap);
      n_evt <= n_evt + evt;
      n_trg <= n_trg + trg;
      n_mi <= n_mi + mi;
      n_clr <= n_clr + clr;
      n_wrp <= n_wrp + wrp;
      if (cycles == 6000) begin
         num_errors = num_errors + 1;
         conclude;
      end
   end
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      rchk(`ADDR_CAPTURE_EDGE, `RST_BYTE);
      rchk(`ADDR_EVENT_TRIG, `RST_BYTE);
      rchk(`ADDR_CAPTURE_MODE, `RST_BYTE);
      rchk(`ADDR_CH0_CC, `RST_CC);
      // random round trips; option bits 3:1 are always written as zero
      repeat (4) begin
         rng = xs(rng);
         wr(`ADDR_CAPTURE_EDGE, rng[15:0]);
         rchk(`ADDR_CAPTURE_EDGE, {8'h00, rng[7:0]});
         wr(`ADDR_EVENT_TRIG, rng[15:0]);
         rchk(`ADDR_EVENT_TRIG, {12'h000, rng[3:0]});
         wr(`ADDR_CAPTURE_MODE, rng[15:0] & 16'h00f1);
         rchk(`ADDR_CAPTURE_MODE, {8'h00, rng[7:4], 4'h0});
         wr(`ADDR_CH0_CC, rng[31:16]);
         rchk(`ADDR_CH0_CC, rng[31:16]);
         rchk(32'hfffff54f, 16'h0000);
      end
      wr(`ADDR_CAPTURE_MODE, 16'h00f0);
      // modes 5, 6, 1, 2, 3 and 0 against every edge code, fields rewritten only while stopped
      for (int k = 0; k < 24; k++) begin
         m = mt[k / 4];
         c = k[1:0];
         en <= 1'b0;
         @(posedge core_clk);
         mode <= m;
         eee <= (k / 4 == 5);
         sel = (k + k / 4) % 4;
         wr(`ADDR_CAPTURE_EDGE, 16'(c) << (2 * sel));
         wr(`ADDR_EVENT_TRIG, {12'h000, c, c});
         rng = xs(rng);
         cnt <= rng[15:0];
         en <= 1'b1;
         b1 = n_sel;
         b2 = n_all;
         b3 = n_evt;
         b4 = n_trg;
         pulse_pins;
         f = (m >= 3'h5) ? edges(c) : 0;
         chk(16'(n_sel - b1), 16'(f));
         chk(16'(n_all - b2), 16'(f));
         chk(16'(n_evt - b3), 16'((m == 3'h1 || k / 4 == 5) ? edges(c) : 0));
         chk(16'(n_trg - b4), 16'((m == 3'h2 || m == 3'h3) ? edges(c) : 0));
         if (sel == 0 && c != 2'h0 && m >= 3'h5) rchk(`ADDR_CH0_CC, cnt);
      end
      en <= 1'b0;
      @(posedge core_clk);
      mode <= 3'h5;
      @(posedge core_clk);
      en <= 1'b1;
      wrap_once;
      rchk(`ADDR_CAPTURE_MODE, 16'h00f1);
      rchk(`ADDR_CAPTURE_MODE, 16'h00f1);
      wr(`ADDR_CAPTURE_MODE, 16'h00f1);
      rchk(`ADDR_CAPTURE_MODE, 16'h00f1);
      wr(`ADDR_CAPTURE_MODE, 16'h00f0);
      rchk(`ADDR_CAPTURE_MODE, 16'h00f0);
      wrap_once;
      en <= 1'b0;
      rchk(`ADDR_CAPTURE_MODE, 16'h00f0);
      mode <= 3'h0;
      @(posedge core_clk);
      en <= 1'b1;
      wrap_once;
      rchk(`ADDR_CAPTURE_MODE, 16'h00f0);
      // interval mode match: first with output toggle off, then on
      en <= 1'b0;
      oe <= 1'b0;
      wr(`ADDR_CH0_CC, 16'h1234);
      en <= 1'b1;
      b1 = n_mi;
      b2 = n_clr;
      repeat (2) begin
         @(posedge core_clk);
         cnt <= 16'h1234;
         repeat (3) @(posedge core_clk);
         chk({15'h0000, tout}, {15'h0000, oe});
         cnt <= 16'h0000;
         oe <= 1'b1;
      end
      chk(16'(n_mi - b1), 16'h0002);
      chk(16'(n_clr - b2), 16'h0002);
      chk(16'(n_wrp), 16'h0002);
      conclude;
   end
endmodule // timer_capture_edge_overflow_test
`default_nettype wire
